// ---- include/charger_cfg.svh ----
// constants of the charger set-point block: codes, resets, fields, scaling, timing.
// assumes a 40 MHz system clock; included by the package and the design.
//
// Behaviour
// - charge word bits 7..12 form the charge code
// - charge code bit weights 128 mA doubling to 4096
// - charge requests above 8.064 A saturate at maximum
// - charge requests below 128 mA give zero current
// - reset clears charge rate, charger stays disabled
// - zero stops charging; start needs both registers valid
// - command 0x14 selects charge rate, write word
// - charge rate register reads back stored contents
// - low battery forces 128 mA until above 2.7 V
// - adapter word bits 7..12 form the adapter code
// - adapter code bit weights 256 mA doubling to 8192
// - adapter requests above 11.004 A saturate there
// - adapter requests below 256 mA give zero limit
// - reset loads adapter limit with 256 mA value
// - command 0x3F selects adapter limit, read and write
// - 175 s without charge rate or end voltage write ends charging
// - clock line low beyond 25 ms ends charging
// - after timeout, a charge rate or end voltage write re-enables charging
// - command 0x15 selects end voltage, reset zero
// - enable needs rate above 0x007F, voltage above 0x000F
// - words travel low byte first, high byte second
// - slave only, answers seven-bit address 0b0001001
`ifndef CHARGER_CFG_SVH
`define CHARGER_CFG_SVH

// bus addressing
`define CHG_SLAVE_ADDR          7'h09
`define CHG_CMD_CHARGE_RATE     8'h14
`define CHG_CMD_END_VOLTAGE     8'h15
`define CHG_CMD_ADAPTER_LIMIT   8'h3F

// reset values
`define CHG_CHARGE_RATE_RST     16'h0000
`define CHG_END_VOLTAGE_RST     16'h0000
`define CHG_ADAPTER_LIMIT_RST   16'h0080

// field positions of the six-bit dac codes
`define CHG_DAC_LSB             7
`define CHG_DAC_MSB             12
`define CHG_DAC_OVER_MSB        15

// validity thresholds for enabling
`define CHG_CHARGE_MIN_VALID    16'h007F
`define CHG_VOLT_MIN_VALID      16'h000F

// current scaling in mA
`define CHG_CHARGE_STEP_MA      128
`define CHG_ADAPTER_STEP_MA     256
`define CHG_CHARGE_MAX_MA       8064
`define CHG_ADAPTER_MAX_MA      11004
`define CHG_FOLD_MA             128

// timing
`define CHG_CLK_PERIOD_NS       25
`define CHG_TICK_NS             100000
`define CHG_TICK_CYCLES         (`CHG_TICK_NS / `CHG_CLK_PERIOD_NS)
`define CHG_WR_TIMEOUT_S        175
`define CHG_WR_TIMEOUT_TICKS    (`CHG_WR_TIMEOUT_S * (1000000000 / `CHG_TICK_NS))
`define CHG_SCL_TIMEOUT_MS      25
`define CHG_SCL_TIMEOUT_TICKS   (`CHG_SCL_TIMEOUT_MS * (1000000 / `CHG_TICK_NS))
`define CHG_TIMER_WIDTH         21

`endif

// ---- include/charger_pkg.sv ----
// types shared by the charger set-point block, its checker and its bench.
// assumes charger_cfg.svh is on the include path.
`include "charger_cfg.svh"

package charger_pkg;

  // serial slave sequencing
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX,
    ST_ACK,
    ST_TX,
    ST_MACK
  } smb_state_t;

  // effective set-points handed to the analog loops
  typedef struct packed {
    logic        enable;
    logic        timed_out;
    logic        fold_active;
    logic [5:0]  charge_dac_code;
    logic [12:0] charge_ma;
    logic [5:0]  adapter_dac_code;
    logic [13:0] adapter_ma;
  } setpoint_t;

endpackage

// ---- core/timeout_counter.sv ----
// one watchdog: counts ticks, pulses once at the limit, holds until restart.
// assumes tick is a one-cycle pulse in the clk_sys domain.
`timescale 1ns/1ps
`default_nettype none
`include "charger_cfg.svh"

module timeout_counter #(
  parameter int unsigned WIDTH = `CHG_TIMER_WIDTH,
  parameter int unsigned LIMIT = `CHG_WR_TIMEOUT_TICKS
) (
  // clock and reset
  input  wire logic clk_sys,
  input  wire logic reset,
  // control
  input  wire logic tick,
  input  wire logic restart,
  // event
  output logic      expire_r
);

  logic [WIDTH-1:0] count_r;    // elapsed ticks
  logic [WIDTH-1:0] count_nxt;
  logic             expire_nxt;

  // next count, saturating at the limit so one expiry gives one pulse
  always_comb begin
    count_nxt  = count_r;
    expire_nxt = 1'b0;
    if (restart) begin
      count_nxt = '0;
    end else if (tick && (count_r != WIDTH'(LIMIT))) begin
      count_nxt  = count_r + WIDTH'(1);
      expire_nxt = (count_r == WIDTH'(LIMIT - 1));
    end
  end

  // registers only
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      count_r  <= '0;
      expire_r <= 1'b0;
    end else begin
      count_r  <= count_nxt;
      expire_r <= expire_nxt;
    end
  end

endmodule // timeout_counter

`default_nettype wire

// ---- core/charger_setpoint_registers.sv ----
// charger set-point registers: bus slave, three words, clamped dac codes,
// low-battery foldback and two watchdogs that end charging.
// assumes scl and sda synchronous to clk_sys and debounced; sda open drain.
`timescale 1ns/1ps
`default_nettype none
`include "charger_cfg.svh"

module charger_setpoint_registers #(
  parameter int unsigned TICK_CYCLES       = `CHG_TICK_CYCLES,
  parameter int unsigned WR_TIMEOUT_TICKS  = `CHG_WR_TIMEOUT_TICKS,
  parameter int unsigned SCL_TIMEOUT_TICKS = `CHG_SCL_TIMEOUT_TICKS
) (
  // clock and reset
  input  wire logic            clk_sys,
  input  wire logic            reset,
  // bus pins
  input  wire logic            scl_in,
  input  wire logic            sda_in,
  output logic                 sda_out,
  output logic                 sda_oe,
  // battery comparators
  input  wire logic            batt_below_low,
  input  wire logic            batt_above_high,
  // effective set-points
  output charger_pkg::setpoint_t setpoint
);

  // pin history for edge and condition detection
  logic scl_q;
  logic sda_q;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  // serial slave state
  charger_pkg::smb_state_t st_r, st_nxt;
  logic [7:0]  shift_r, shift_nxt;       // received byte
  logic [3:0]  bit_r, bit_nxt;           // bits moved in this byte
  logic [2:0]  byte_r, byte_nxt;         // byte index in transaction
  logic        rw_r, rw_nxt;             // read requested
  logic [7:0]  cmd_r, cmd_nxt;           // selected register, kept across transactions
  logic [7:0]  lo_r, lo_nxt;             // low byte in, high byte out
  logic [7:0]  tx_r, tx_nxt;             // outgoing shift
  logic        oe_r, oe_nxt;             // pulling sda low
  logic        ack_r, ack_nxt;           // master acked our byte
  logic        wr_pend_r, wr_pend_nxt;   // full word waiting for stop
  logic [15:0] wr_data_r, wr_data_nxt;   // word waiting for stop
  logic        commit;                   // word lands on this cycle
  logic [15:0] rd_word;                  // word selected for reading

  // word registers
  logic [15:0] charge_rate_r, charge_rate_nxt;
  logic [15:0] end_voltage_r, end_voltage_nxt;
  logic [15:0] adapter_limit_r, adapter_limit_nxt;
  logic        kick;                     // charge rate or end voltage written

  // prescaler and watchdog state
  logic [12:0] tick_cnt_r, tick_cnt_nxt;
  logic        tick_r, tick_nxt;
  logic        wr_expire;
  logic        scl_expire;
  logic        timed_out_r, timed_out_nxt;
  logic        fold_r, fold_nxt;

  // output staging
  charger_pkg::setpoint_t setpoint_nxt;
  logic [5:0]  charge_code;
  logic [5:0]  adapter_code;
  logic [13:0] adapter_raw_ma;
  logic        enable_now;

  // bus conditions
  assign scl_rise   = scl_in & ~scl_q;
  assign scl_fall   = ~scl_in & scl_q;
  assign start_cond = scl_in & scl_q & sda_q & ~sda_in;
  assign stop_cond  = scl_in & scl_q & ~sda_q & sda_in;

  // read mux; unmapped commands read as zero
  always_comb begin
    unique case (cmd_r)
      `CHG_CMD_CHARGE_RATE:   rd_word = charge_rate_r;
      `CHG_CMD_END_VOLTAGE:   rd_word = end_voltage_r;
      `CHG_CMD_ADAPTER_LIMIT: rd_word = adapter_limit_r;
      default:                rd_word = 16'h0000;
    endcase
  end

  // serial slave next state; a start always wins, even mid-byte
  always_comb begin
    st_nxt      = st_r;
    shift_nxt   = shift_r;
    bit_nxt     = bit_r;
    byte_nxt    = byte_r;
    rw_nxt      = rw_r;
    cmd_nxt     = cmd_r;
    lo_nxt      = lo_r;
    tx_nxt      = tx_r;
    oe_nxt      = oe_r;
    ack_nxt     = ack_r;
    wr_pend_nxt = wr_pend_r;
    wr_data_nxt = wr_data_r;
    commit      = 1'b0;
    if (start_cond) begin
      // repeated start discards a half-written word
      st_nxt      = charger_pkg::ST_RX;
      bit_nxt     = 4'h0;
      byte_nxt    = 3'h0;
      oe_nxt      = 1'b0;
      wr_pend_nxt = 1'b0;
    end else if (stop_cond) begin
      // word lands at the stop
      st_nxt      = charger_pkg::ST_IDLE;
      oe_nxt      = 1'b0;
      commit      = wr_pend_r;
      wr_pend_nxt = 1'b0;
    end else begin
      unique case (st_r)
        charger_pkg::ST_IDLE: begin
          // never drives the bus
          oe_nxt = 1'b0;
        end
        charger_pkg::ST_RX: begin
          if (scl_rise) begin
            // msb first
            shift_nxt = {shift_r[6:0], sda_in};
            bit_nxt   = bit_r + 4'h1;
          end else if (scl_fall && (bit_r == 4'h8)) begin
            bit_nxt = 4'h0;
            st_nxt  = charger_pkg::ST_ACK;
            oe_nxt  = 1'b1;
            unique case (byte_r)
              3'h0: begin
                // foreign address: stay silent
                if (shift_r[7:1] != `CHG_SLAVE_ADDR) begin
                  st_nxt = charger_pkg::ST_IDLE;
                  oe_nxt = 1'b0;
                end else begin
                  rw_nxt = shift_r[0];
                end
              end
              3'h1: cmd_nxt = shift_r;
              3'h2: lo_nxt  = shift_r;
              3'h3: begin
                wr_data_nxt = {shift_r, lo_r};
                wr_pend_nxt = 1'b1;
              end
              default: begin
                // extra bytes refused
                st_nxt      = charger_pkg::ST_IDLE;
                oe_nxt      = 1'b0;
                wr_pend_nxt = 1'b0;
              end
            endcase
          end
        end
        charger_pkg::ST_ACK: begin
          if (scl_fall) begin
            if (rw_r) begin
              // low byte first, high byte parked
              oe_nxt   = ~rd_word[7];
              tx_nxt   = {rd_word[6:0], 1'b0};
              lo_nxt   = rd_word[15:8];
              bit_nxt  = 4'h1;
              byte_nxt = 3'h0;
              st_nxt   = charger_pkg::ST_TX;
            end else begin
              oe_nxt   = 1'b0;
              byte_nxt = byte_r + 3'h1;
              st_nxt   = charger_pkg::ST_RX;
            end
          end
        end
        charger_pkg::ST_TX: begin
          if (scl_fall) begin
            if (bit_r == 4'h8) begin
              // release for the master's ack
              oe_nxt = 1'b0;
              st_nxt = charger_pkg::ST_MACK;
            end else begin
              oe_nxt  = ~tx_r[7];
              tx_nxt  = {tx_r[6:0], 1'b0};
              bit_nxt = bit_r + 4'h1;
            end
          end
        end
        charger_pkg::ST_MACK: begin
          if (scl_rise) begin
            ack_nxt = ~sda_in;
          end else if (scl_fall) begin
            if (ack_r && (byte_r == 3'h0)) begin
              oe_nxt   = ~lo_r[7];
              tx_nxt   = {lo_r[6:0], 1'b0};
              bit_nxt  = 4'h1;
              byte_nxt = 3'h1;
              st_nxt   = charger_pkg::ST_TX;
            end else begin
              // nack or second byte done: release
              oe_nxt = 1'b0;
              st_nxt = charger_pkg::ST_IDLE;
            end
          end
        end
      endcase
    end
  end

  // serial slave registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      scl_q     <= 1'b1;
      sda_q     <= 1'b1;
      st_r      <= charger_pkg::ST_IDLE;
      shift_r   <= 8'h00;
      bit_r     <= 4'h0;
      byte_r    <= 3'h0;
      rw_r      <= 1'b0;
      cmd_r     <= 8'h00;
      lo_r      <= 8'h00;
      tx_r      <= 8'h00;
      oe_r      <= 1'b0;
      ack_r     <= 1'b0;
      wr_pend_r <= 1'b0;
      wr_data_r <= 16'h0000;
    end else begin
      scl_q     <= scl_in;
      sda_q     <= sda_in;
      st_r      <= st_nxt;
      shift_r   <= shift_nxt;
      bit_r     <= bit_nxt;
      byte_r    <= byte_nxt;
      rw_r      <= rw_nxt;
      cmd_r     <= cmd_nxt;
      lo_r      <= lo_nxt;
      tx_r      <= tx_nxt;
      oe_r      <= oe_nxt;
      ack_r     <= ack_nxt;
      wr_pend_r <= wr_pend_nxt;
      wr_data_r <= wr_data_nxt;
    end
  end

  // word registers: all 16 bits kept for read-back
  always_comb begin
    charge_rate_nxt   = charge_rate_r;
    end_voltage_nxt   = end_voltage_r;
    adapter_limit_nxt = adapter_limit_r;
    kick              = 1'b0;
    if (commit) begin
      unique case (cmd_r)
        `CHG_CMD_CHARGE_RATE: begin
          charge_rate_nxt = wr_data_r;
          kick            = 1'b1;
        end
        `CHG_CMD_END_VOLTAGE: begin
          end_voltage_nxt = wr_data_r;
          kick            = 1'b1;
        end
        `CHG_CMD_ADAPTER_LIMIT: adapter_limit_nxt = wr_data_r;
        default: ;
      endcase
    end
  end

  // register bank reset values
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      charge_rate_r   <= `CHG_CHARGE_RATE_RST;
      end_voltage_r   <= `CHG_END_VOLTAGE_RST;
      adapter_limit_r <= `CHG_ADAPTER_LIMIT_RST;
    end else begin
      charge_rate_r   <= charge_rate_nxt;
      end_voltage_r   <= end_voltage_nxt;
      adapter_limit_r <= adapter_limit_nxt;
    end
  end

  // tick prescaler; coarse ticks keep the long watchdog narrow
  always_comb begin
    tick_nxt     = 1'b0;
    tick_cnt_nxt = tick_cnt_r + 13'h0001;
    if (tick_cnt_r == 13'(TICK_CYCLES - 1)) begin
      tick_cnt_nxt = 13'h0000;
      tick_nxt     = 1'b1;
    end
  end

  // write watchdog: restarted by every charge rate or end voltage write
  timeout_counter #(
    .WIDTH (`CHG_TIMER_WIDTH),
    .LIMIT (WR_TIMEOUT_TICKS)
  ) u_wr_watchdog (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .tick     (tick_r),
    .restart  (kick),
    .expire_r (wr_expire)
  );

  // clock-low watchdog: one tick past the limit means strictly longer
  timeout_counter #(
    .WIDTH (`CHG_TIMER_WIDTH),
    .LIMIT (SCL_TIMEOUT_TICKS + 1)
  ) u_scl_watchdog (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .tick     (tick_r),
    .restart  (scl_q),
    .expire_r (scl_expire)
  );

  // timeout latch and foldback hysteresis; a new expiry beats a clearing write
  always_comb begin
    timed_out_nxt = timed_out_r;
    if (wr_expire || scl_expire) begin
      timed_out_nxt = 1'b1;
    end else if (kick) begin
      timed_out_nxt = 1'b0;
    end
    fold_nxt = fold_r;
    if (batt_below_low) begin
      fold_nxt = 1'b1;
    end else if (batt_above_high) begin
      fold_nxt = 1'b0;
    end
  end

  // effective set-points: saturate on any bit above the field
  always_comb begin
    charge_code  = (|charge_rate_r[`CHG_DAC_OVER_MSB:`CHG_DAC_MSB+1]) ? 6'h3F
                   : charge_rate_r[`CHG_DAC_MSB:`CHG_DAC_LSB];
    adapter_code = (|adapter_limit_r[`CHG_DAC_OVER_MSB:`CHG_DAC_MSB+1]) ? 6'h3F
                   : adapter_limit_r[`CHG_DAC_MSB:`CHG_DAC_LSB];
    adapter_raw_ma = 14'(adapter_code) * 14'(`CHG_ADAPTER_STEP_MA);
    enable_now = (charge_rate_r > `CHG_CHARGE_MIN_VALID)
               && (end_voltage_r > `CHG_VOLT_MIN_VALID)
               && !timed_out_r;
    setpoint_nxt.enable      = enable_now;
    setpoint_nxt.timed_out   = timed_out_r;
    setpoint_nxt.fold_active = fold_r;
    if (!enable_now) begin
      setpoint_nxt.charge_dac_code = 6'h00;
    end else if (fold_r) begin
      // foldback leaves the stored word untouched
      setpoint_nxt.charge_dac_code = 6'(`CHG_FOLD_MA / `CHG_CHARGE_STEP_MA);
    end else begin
      setpoint_nxt.charge_dac_code = charge_code;
    end
    setpoint_nxt.charge_ma = 13'(setpoint_nxt.charge_dac_code) * 13'(`CHG_CHARGE_STEP_MA);
    setpoint_nxt.adapter_dac_code = adapter_code;
    setpoint_nxt.adapter_ma = (adapter_raw_ma > 14'(`CHG_ADAPTER_MAX_MA))
                              ? 14'(`CHG_ADAPTER_MAX_MA) : adapter_raw_ma;
  end

  // watchdog, foldback and output registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      tick_cnt_r  <= 13'h0000;
      tick_r      <= 1'b0;
      timed_out_r <= 1'b0;
      fold_r      <= 1'b0;
      setpoint    <= '0;
      sda_oe      <= 1'b0;
      sda_out     <= 1'b0;
    end else begin
      tick_cnt_r  <= tick_cnt_nxt;
      tick_r      <= tick_nxt;
      timed_out_r <= timed_out_nxt;
      fold_r      <= fold_nxt;
      setpoint    <= setpoint_nxt;
      sda_oe      <= oe_nxt;
      sda_out     <= 1'b0;                                 // open drain: only ever pulls low
    end
  end

endmodule // charger_setpoint_registers

`default_nettype wire

// ---- dv/charger_setpoint_registers_assertions.sv ----
// concurrent checks on the charger set-point block's top ports.
// assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module charger_setpoint_registers_checker #(
  parameter int unsigned TICK_CYCLES       = 4,
  parameter int unsigned WR_TIMEOUT_TICKS  = 20,
  parameter int unsigned SCL_TIMEOUT_TICKS = 5
) (
  // clock and reset
  input wire logic                   clk_sys,
  input wire logic                   reset,
  // bus pins
  input wire logic                   scl_in,
  input wire logic                   sda_in,
  input wire logic                   sda_out,
  input wire logic                   sda_oe,
  // battery comparators
  input wire logic                   batt_below_low,
  input wire logic                   batt_above_high,
  // effective set-points
  input wire charger_pkg::setpoint_t setpoint
);
  // one tick of jitter plus the output flops on top of the limit
  localparam int unsigned SCL_LIMIT = (SCL_TIMEOUT_TICKS + 3) * TICK_CYCLES;

  logic [15:0] low_cnt_r;   // cycles the bus clock has stayed low
  logic [15:0] low_cnt_nxt; // saturates so a stuck line never wraps

  // cleared while scl is high
  always_comb begin
    low_cnt_nxt = low_cnt_r;
    if (scl_in) low_cnt_nxt = 16'h0000;
    else if (low_cnt_r != 16'hffff) low_cnt_nxt = low_cnt_r + 16'h0001;
  end

  // register only
  always_ff @(posedge clk_sys) begin
    if (reset) low_cnt_r <= 16'h0000;
    else low_cnt_r <= low_cnt_nxt;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  reset_quiet_a: assert property (disable iff (1'b0) reset |=> setpoint == '0 && !sda_oe)
    else $error("reset outputs");
  timeout_off_a: assert property ($rose(setpoint.timed_out) |=> !setpoint.enable)
    else $error("enable after timeout");
  off_zero_a: assert property (!setpoint.enable |-> setpoint.charge_dac_code == 6'h00)
    else $error("code while disabled");
  charge_scale_a: assert property (setpoint.charge_ma == {setpoint.charge_dac_code, 7'h00})
    else $error("charge scaling");
  adapter_scale_a: assert property (setpoint.adapter_ma == ((setpoint.adapter_dac_code > 6'h2a) ?
    14'h2afc : {setpoint.adapter_dac_code, 8'h00})) else $error("adapter scaling");
  fold_set_a: assert property (batt_below_low [*3] |-> setpoint.fold_active)
    else $error("fold not set");
  fold_clear_a: assert property ((batt_above_high && !batt_below_low) [*3] |-> !setpoint.fold_active)
    else $error("fold not cleared");
  fold_code_a: assert property ((setpoint.fold_active && setpoint.enable) [*2] |->
    setpoint.charge_dac_code == 6'h01) else $error("fold code");
  oe_steady_a: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
    else $error("sda_oe moved, scl high");
  slave_only_a: assert property (!sda_out)
    else $error("sda_out high");
  scl_watch_a: assert property ({16'h0000, low_cnt_r} > SCL_LIMIT |-> setpoint.timed_out)
    else $error("no scl timeout");
endmodule // charger_setpoint_registers_checker

bind charger_setpoint_registers charger_setpoint_registers_checker #(
  .TICK_CYCLES(TICK_CYCLES), .WR_TIMEOUT_TICKS(WR_TIMEOUT_TICKS), .SCL_TIMEOUT_TICKS(SCL_TIMEOUT_TICKS)
) u_checker (
  .clk_sys(clk_sys), .reset(reset), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .batt_below_low(batt_below_low), .batt_above_high(batt_above_high),
  .setpoint(setpoint)
);
`default_nettype wire

// ---- dv/smb_host_model.sv ----
// bus master model: drives the clock line and an open-drain data line.
// assumes pull-ups on both lines; the bench calls its tasks by hierarchy.
`timescale 1ns/1ps
`default_nettype none
`include "charger_cfg.svh"

module smb_host_model (
  // clock
  input  wire logic clk_sys,
  // bus lines
  input  wire logic sda_oe,
  output logic      scl_in,
  output logic      sda_in
);
  logic sda_m; // own drive, 1 = released
  int   nacks; // ack slots that came back high

  // wired-and: the pull-up wins only if nobody pulls low
  assign sda_in = sda_m & ~sda_oe;

  // idle bus at time zero
  initial begin
    scl_in = 1'b1;
    sda_m  = 1'b1;
    nacks  = 0;
  end

  task automatic ph(input int unsigned n);
    repeat (n) @(posedge clk_sys);
  endtask
  // both lines, then four clocks
  task automatic set(input logic c, input logic d);
    scl_in <= c;
    sda_m  <= d;
    ph(4);
  endtask
  // four-clock phases; sample mid-high
  task automatic bit_io(input logic b, output logic s);
    sda_m <= b;
    ph(4);
    scl_in <= 1'b1;
    ph(2);
    s = sda_in;
    ph(2);
    scl_in <= 1'b0;
  endtask
  // byte out msb first, then the slave's ack slot
  task automatic put(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    if (s !== 1'b0) nacks++;
  endtask
  // byte in, then our ack or nack
  task automatic get(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(~ack, s);
  endtask
  // start; clock low before bit one
  task automatic strt;
    set(1'b1, 1'b1);
    set(1'b1, 1'b0);
    set(1'b0, 1'b0);
  endtask
  task automatic stp;
    sda_m <= 1'b0;
    ph(4);
    set(1'b1, 1'b0);
    set(1'b1, 1'b1);
  endtask
  // write word: low byte first
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [15:0] w);
    strt;
    put({a, 1'b0});
    put(c);
    put(w[7:0]);
    put(w[15:8]);
    stp;
  endtask
  // pointer write and stop, then a fresh start for the read
  task automatic rd(input logic [7:0] c, output logic [15:0] w);
    strt;
    put({`CHG_SLAVE_ADDR, 1'b0});
    put(c);
    stp;
    strt;
    put({`CHG_SLAVE_ADDR, 1'b1});
    get(1'b1, w[7:0]);
    get(1'b0, w[15:8]);
    stp;
  endtask
  // stall with the clock held low
  task automatic hold_low(input int unsigned n);
    scl_in <= 1'b0;
    ph(n);
    scl_in <= 1'b1;
    ph(4);
  endtask
endmodule // smb_host_model
`default_nettype wire

// ---- dv/tb_charger_setpoint_registers.sv ----
// self-checking bench: master model, shortened watchdogs, corner and random words.
// assumes the header, package and design are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "charger_cfg.svh"

module tb_charger_setpoint_registers;
  localparam int unsigned TK = 4;    // clocks per tick, shortened
  localparam int unsigned WT = 1000; // write watchdog ticks, longer than a read pair
  localparam int unsigned ST = 5;    // clock-low watchdog ticks

  logic                   clk_sys = 1'b0;         // 40 MHz
  logic                   reset = 1'b1;           // held at start
  logic                   batt_below_low = 1'b0;  // below 2.5 V
  logic                   batt_above_high = 1'b0; // above 2.7 V
  logic                   scl_in, sda_in;         // driven by the model
  logic                   sda_out, sda_oe;        // device data drive
  charger_pkg::setpoint_t setpoint;               // effective set-points
  logic [15:0]            chg, volt, adp;         // expected register contents
  logic                   tmo, fold;              // expected watchdog and foldback
  int                     n_fail = 0;
  int                     total_checks = 0;
  int unsigned            rnd;
  logic [15:0]            corner [6] = '{16'h0000, 16'h007f, 16'h0080, 16'h1f80, 16'h2000, 16'hffff};

  charger_setpoint_registers #(
    .TICK_CYCLES(TK), .WR_TIMEOUT_TICKS(WT), .SCL_TIMEOUT_TICKS(ST)
  ) DUT (
    .clk_sys(clk_sys), .reset(reset), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .batt_below_low(batt_below_low), .batt_above_high(batt_above_high),
    .setpoint(setpoint)
  );
  smb_host_model u_host (.clk_sys(clk_sys), .sda_oe(sda_oe), .scl_in(scl_in), .sda_in(sda_in));

  // half period of 12.5 ns
  always #12.5 clk_sys = ~clk_sys;

  task automatic ph(input int unsigned n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // six-bit code, saturated
  function automatic logic [5:0] code(input logic [15:0] v);
    return (|v[15:13]) ? 6'h3f : v[12:7];
  endfunction
  // sample at the falling edge, away from the flops
  task automatic sp_check;
    logic       en;
    logic [5:0] cc;
    en = chg > 16'h007f && volt > 16'h000f && !tmo;
    cc = !en ? 6'h00 : fold ? 6'h01 : code(chg);
    @(negedge clk_sys);
    chk("enable", 16'(en), 16'(setpoint.enable));
    chk("charge_code", 16'(cc), 16'(setpoint.charge_dac_code));
    chk("charge_ma", 16'(cc * 128), 16'(setpoint.charge_ma));
    chk("adapter_code", 16'(code(adp)), 16'(setpoint.adapter_dac_code));
    chk("adapter_ma", 16'((code(adp) > 42) ? 11004 : code(adp) * 256), 16'(setpoint.adapter_ma));
    @(posedge clk_sys);
  endtask
  // write word, let the flops settle
  task automatic wr(input logic [7:0] c, input logic [15:0] v);
    u_host.wr(`CHG_SLAVE_ADDR, c, v);
    if (c == `CHG_CMD_CHARGE_RATE) chg = v;
    if (c == `CHG_CMD_END_VOLTAGE) volt = v;
    if (c == `CHG_CMD_ADAPTER_LIMIT) adp = v;
    if (c == `CHG_CMD_CHARGE_RATE || c == `CHG_CMD_END_VOLTAGE) tmo = 1'b0;
    ph(3);
  endtask
  task automatic rb(input logic [7:0] c, input logic [15:0] e);
    logic [15:0] g;
    u_host.rd(c, g);
    chk("readback", e, g);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    rnd = $urandom(32'h5ab1);
    {chg, volt, tmo, fold} = '0;
    adp = 16'h0080;
    ph(6);
    reset <= 1'b0;
    ph(3);
    sp_check;
    rb(`CHG_CMD_CHARGE_RATE, 16'h0000);
    rb(`CHG_CMD_END_VOLTAGE, 16'h0000);
    rb(`CHG_CMD_ADAPTER_LIMIT, 16'h0080);
    // voltage at its threshold keeps the charger off
    wr(`CHG_CMD_END_VOLTAGE, 16'h000f);
    wr(`CHG_CMD_CHARGE_RATE, 16'h0080);
    sp_check;
    wr(`CHG_CMD_END_VOLTAGE, 16'h0010);
    sp_check;
    // clamp and threshold corners on both words
    foreach (corner[i]) begin
      wr(`CHG_CMD_CHARGE_RATE, corner[i]);
      wr(`CHG_CMD_ADAPTER_LIMIT, corner[i]);
      sp_check;
    end
    repeat (12) begin
      wr(`CHG_CMD_CHARGE_RATE, 16'($urandom));
      wr(`CHG_CMD_ADAPTER_LIMIT, 16'($urandom));
      rb(`CHG_CMD_CHARGE_RATE, chg);
      rb(`CHG_CMD_ADAPTER_LIMIT, adp);
      sp_check;
    end
    wr(`CHG_CMD_CHARGE_RATE, 16'h0000);
    sp_check;
    // unknown command is acked, ignored and reads as zero
    wr(8'h20, 16'h1234);
    rb(8'h20, 16'h0000);
    // foreign address: nothing acked, nothing stored
    rnd = u_host.nacks;
    chk("nacks", 16'h0000, 16'(rnd));
    u_host.wr(7'h0a, `CHG_CMD_CHARGE_RATE, 16'h0f80);
    chk("nacks", 16'(rnd + 4), 16'(u_host.nacks));
    rb(`CHG_CMD_CHARGE_RATE, 16'h0000);
    // foldback holds between the two thresholds
    wr(`CHG_CMD_CHARGE_RATE, 16'h1000);
    batt_below_low <= 1'b1;
    fold = 1'b1;
    ph(4);
    sp_check;
    rb(`CHG_CMD_CHARGE_RATE, 16'h1000);
    batt_below_low <= 1'b0;
    ph(4);
    sp_check;
    batt_above_high <= 1'b1;
    fold = 1'b0;
    ph(4);
    sp_check;
    batt_above_high <= 1'b0;
    // write watchdog; adapter writes must not rearm
    ph(WT * TK + 3 * TK);
    tmo = 1'b1;
    sp_check;
    wr(`CHG_CMD_ADAPTER_LIMIT, 16'h0400);
    sp_check;
    wr(`CHG_CMD_END_VOLTAGE, 16'h0010);
    sp_check;
    u_host.hold_low((ST + 4) * TK);
    tmo = 1'b1;
    ph(3);
    sp_check;
    wr(`CHG_CMD_CHARGE_RATE, 16'h0800);
    sp_check;
    results;
  end

  // hang guard, well past the expected run length
  initial begin
    ph(90000);
    n_fail++;
    results;
  end
endmodule // tb_charger_setpoint_registers
`default_nettype wire
